/* File: include/edge_detector_regs.vh */
// Purpose: Constants for the edge detector parameter port and defaults.
// Assumes: Included by the edge detector design file and by the bench.
// Notes: Addresses are the four-bit parameter port addresses.
`ifndef EDGE_DETECTOR_REGS_VH
`define EDGE_DETECTOR_REGS_VH

`define ADDR_FRAME_WIDTH 4'h0
`define ADDR_FRAME_HEIGHT 4'h1
`define ADDR_ORIGIN_X 4'h2
`define ADDR_ORIGIN_Y 4'h3
`define ADDR_REGION_W1 4'h4
`define ADDR_REGION_H1 4'h5
`define ADDR_ALGORITHM 4'h6
`define ADDR_THRESHOLD 4'h7
`define ADDR_COMMIT 4'h8

`define RST_FRAME_WIDTH 24'h000140
`define RST_FRAME_HEIGHT 24'h0000f0
`define RST_ORIGIN_X 24'h000000
`define RST_ORIGIN_Y 24'h000000
`define RST_REGION_W1 24'h00013f
`define RST_REGION_H1 24'h0000ef
`define RST_THRESHOLD 24'h000000

`define ALG_FIRST 1'h0
`define ALG_SECOND 1'h1

`define EDGE_COPY 2'h0
`define EDGE_MIRROR 2'h1
`define EDGE_VALUE 2'h2

`endif

/* File: design/edge_detector.v */
// Purpose: Single-plane 3x3 gradient edge detector with line buffers.
// Assumes: Source and sink run on clk; frames are W x H pixels.
// Notes: An extra column per row and an extra row per frame are
// generated internally (ready low) to flush the window.
`include "edge_detector_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module edge_detector #(
   parameter DW = 8,
   parameter TW = 1,
   parameter MAX_W = 2000,
   parameter AW = 11,
   parameter RW = 24,
   parameter DYNAMIC = 1,
   parameter USE_SRST = 1,
   parameter USE_CLKEN = 1,
   parameter [1:0] EDGE_MODE = `EDGE_COPY,
   parameter [DW-1:0] EDGE_VAL = 0
) (
   input wire clk,
   input wire rstn,
   input wire srst,
   input wire clken,
   output reg ready,
   input wire dvalid_in,
   input wire frmsync_in,
   input wire [DW-1:0] din,
   input wire [TW-1:0] tags_in,
   output reg dvalid_out,
   output reg frmsync_out,
   output reg dout,
   output reg [TW-1:0] tags_out,
   input wire pwrite,
   input wire [3:0] paddr,
   input wire [RW-1:0] pwdat,
   output reg [RW-1:0] prdat
);
   localparam G = DW + 4;

   // Software copies of the parameters.
   reg [RW-1:0] fw_q, fh_q, ox_q, oy_q, aw_q, ah_q, thr_q;
   reg alg_q, commit_q;
   // Copies in use by the frame logic.
   reg [RW-1:0] w_q, h_q, aox_q, aoy_q, aaw_q, aah_q;
   reg [RW-1:0] x_q, y_q;
   reg in_frame_q;

   reg [DW-1:0] lb0 [0:MAX_W-1];
   reg [DW-1:0] lb1 [0:MAX_W-1];
   reg [TW-1:0] tb0 [0:MAX_W-1];
   reg [DW-1:0] c1t_q, c1m_q, c1b_q, c2t_q, c2m_q, c2b_q;
   reg [TW-1:0] ct1_q;

   wire run = !USE_CLKEN || clken;
   wire sclr = USE_SRST && srst;
   wire wr_en = (DYNAMIC != 0) && pwrite && run;

   // A transfer needs valid and ready together.
   wire accept = run && ready && dvalid_in;
   wire take = accept && (in_frame_q || frmsync_in);
   // Flush slots step the window with no input, so the last column
   // and the last row still reach the output; ready is low for them.
   wire insert = run && in_frame_q && !(accept && frmsync_in) &&
      (x_q == w_q || y_q == h_q);
   wire step = take || insert;

   // A sync pixel always restarts the frame at the origin.
   wire [RW-1:0] px = (accept && frmsync_in) ? {RW{1'b0}} : x_q;
   wire [RW-1:0] py = (accept && frmsync_in) ? {RW{1'b0}} : y_q;
   wire end_step = step && px == w_q && py == h_q;
   wire [RW-1:0] nx = (px == w_q) ? {RW{1'b0}} : px + 1'b1;
   wire [RW-1:0] ny = end_step ? {RW{1'b0}} :
      (px == w_q) ? py + 1'b1 : py;
   // Hand-over waits for the last flush step, or happens at once when
   // idle, so that no frame mixes old and new region settings.
   wire commit_now = commit_q && (end_step || (!in_frame_q && !accept));
   wire [AW-1:0] idx = px[AW-1:0];
   wire col_real = px < w_q;

   function [DW-1:0] fill;
      input [DW-1:0] centre;
      input [DW-1:0] opposite;
      begin
         case (EDGE_MODE)
            `EDGE_COPY: fill = centre;
            `EDGE_MIRROR: fill = opposite;
            default: fill = EDGE_VAL;
         endcase
      end
   endfunction

   // Raw column for this step: two stored rows and the new pixel.
   wire [DW-1:0] top_r = lb1[idx];
   wire [DW-1:0] mid_r = lb0[idx];
   wire [DW-1:0] bot_r = (py < h_q) ? din : {DW{1'b0}};
   wire top_miss = py == 1;
   wire bot_miss = py == h_q;
   wire [DW-1:0] nt = top_miss ? fill(mid_r, bot_r) : top_r;
   wire [DW-1:0] nb = bot_miss ? fill(mid_r, top_r) : bot_r;
   wire left_miss = px == 1;
   wire right_miss = px == w_q;

   // Window rows t, m, b and columns 0, 1, 2 around the centre.
   wire [DW-1:0] t0 = left_miss ? fill(c1t_q, nt) : c2t_q;
   wire [DW-1:0] m0 = left_miss ? fill(c1m_q, mid_r) : c2m_q;
   wire [DW-1:0] b0 = left_miss ? fill(c1b_q, nb) : c2b_q;
   wire [DW-1:0] t2 = right_miss ? fill(c1t_q, c2t_q) : nt;
   wire [DW-1:0] m2 = right_miss ? fill(c1m_q, c2m_q) : mid_r;
   wire [DW-1:0] b2 = right_miss ? fill(c1b_q, c2b_q) : nb;

   // The middle tap weighs two for the first method: a shift, no
   // multiplier, keeps the adders narrow.
   wire [G-1:0] wm = (alg_q == `ALG_FIRST) ?
      {3'h0, m0, 1'b0} : {4'h0, m0};
   wire [G-1:0] wm2 = (alg_q == `ALG_FIRST) ?
      {3'h0, m2, 1'b0} : {4'h0, m2};
   wire [G-1:0] wt = (alg_q == `ALG_FIRST) ?
      {3'h0, c1t_q, 1'b0} : {4'h0, c1t_q};
   wire [G-1:0] wb = (alg_q == `ALG_FIRST) ?
      {3'h0, c1b_q, 1'b0} : {4'h0, c1b_q};
   // Horizontal: right column minus left column.
   wire [G-1:0] gx_p = {4'h0, t2} + wm2 + {4'h0, b2};
   wire [G-1:0] gx_n = {4'h0, t0} + wm + {4'h0, b0};
   // Vertical: bottom row minus top row.
   wire [G-1:0] gy_p = {4'h0, b0} + wb + {4'h0, b2};
   wire [G-1:0] gy_n = {4'h0, t0} + wt + {4'h0, t2};
   wire [G-1:0] ax = (gx_p >= gx_n) ? gx_p - gx_n : gx_n - gx_p;
   wire [G-1:0] ay = (gy_p >= gy_n) ? gy_p - gy_n : gy_n - gy_p;
   wire [G:0] mag = {1'b0, ax} + {1'b0, ay};
   // Both sides are widened to one common width, so the compare is
   // unsigned and no bit of the threshold is dropped.
   wire edge_bit = {{RW{1'b0}}, mag} >
      {{(G+1){1'b0}}, thr_q};

   // Output only centres inside the active region.
   wire [RW-1:0] cx = px - 1'b1;
   wire [RW-1:0] cy = py - 1'b1;
   wire in_reg = px != 0 && py != 0 && cx >= aox_q &&
      cx <= aox_q + aaw_q && cy >= aoy_q && cy <= aoy_q + aah_q;
   wire first_px = cx == aox_q && cy == aoy_q;

   // Ready drops only for the internally generated flush slots.
   wire nin = step ? !end_step : in_frame_q;
   wire [RW-1:0] rx = step ? nx : x_q;
   wire [RW-1:0] ry = step ? ny : y_q;
   wire [RW-1:0] rw = commit_now ? fw_q : w_q;
   wire [RW-1:0] rh = commit_now ? fh_q : h_q;
   wire ready_d = !(nin && (rx == rw || ry == rh));

   // The read path is combinational on purpose: it must follow the
   // address with no read strobe and no extra cycle of delay.
   always @* begin
      case (paddr)
         `ADDR_FRAME_WIDTH: prdat = fw_q;
         `ADDR_FRAME_HEIGHT: prdat = fh_q;
         `ADDR_ORIGIN_X: prdat = ox_q;
         `ADDR_ORIGIN_Y: prdat = oy_q;
         `ADDR_REGION_W1: prdat = aw_q;
         `ADDR_REGION_H1: prdat = ah_q;
         `ADDR_ALGORITHM: prdat = {{(RW-1){1'b0}}, alg_q};
         `ADDR_THRESHOLD: prdat = thr_q;
         `ADDR_COMMIT: prdat = {{(RW-1){1'b0}}, commit_q};
         default: prdat = {RW{1'b0}};
      endcase
   end

   // Line buffers and window columns hold data only, so no reset.
   always @(posedge clk) begin
      if (step) begin
         c2t_q <= c1t_q;
         c2m_q <= c1m_q;
         c2b_q <= c1b_q;
         c1t_q <= nt;
         c1m_q <= mid_r;
         c1b_q <= nb;
         ct1_q <= tb0[idx];
         if (col_real) begin
            lb1[idx] <= mid_r;
            lb0[idx] <= bot_r;
            tb0[idx] <= tags_in;
         end
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fw_q <= `RST_FRAME_WIDTH;
         fh_q <= `RST_FRAME_HEIGHT;
         ox_q <= `RST_ORIGIN_X;
         oy_q <= `RST_ORIGIN_Y;
         aw_q <= `RST_REGION_W1;
         ah_q <= `RST_REGION_H1;
         alg_q <= `ALG_FIRST;
         thr_q <= `RST_THRESHOLD;
         commit_q <= 1'b0;
         w_q <= `RST_FRAME_WIDTH;
         h_q <= `RST_FRAME_HEIGHT;
         aox_q <= `RST_ORIGIN_X;
         aoy_q <= `RST_ORIGIN_Y;
         aaw_q <= `RST_REGION_W1;
         aah_q <= `RST_REGION_H1;
         x_q <= {RW{1'b0}};
         y_q <= {RW{1'b0}};
         in_frame_q <= 1'b0;
         ready <= 1'b1;
         dvalid_out <= 1'b0;
         frmsync_out <= 1'b0;
         dout <= 1'b0;
         tags_out <= {TW{1'b0}};
      end else if (sclr) begin
         fw_q <= `RST_FRAME_WIDTH;
         fh_q <= `RST_FRAME_HEIGHT;
         ox_q <= `RST_ORIGIN_X;
         oy_q <= `RST_ORIGIN_Y;
         aw_q <= `RST_REGION_W1;
         ah_q <= `RST_REGION_H1;
         alg_q <= `ALG_FIRST;
         thr_q <= `RST_THRESHOLD;
         commit_q <= 1'b0;
         w_q <= `RST_FRAME_WIDTH;
         h_q <= `RST_FRAME_HEIGHT;
         aox_q <= `RST_ORIGIN_X;
         aoy_q <= `RST_ORIGIN_Y;
         aaw_q <= `RST_REGION_W1;
         aah_q <= `RST_REGION_H1;
         x_q <= {RW{1'b0}};
         y_q <= {RW{1'b0}};
         in_frame_q <= 1'b0;
         ready <= 1'b1;
         dvalid_out <= 1'b0;
         frmsync_out <= 1'b0;
         dout <= 1'b0;
         tags_out <= {TW{1'b0}};
      end else if (run) begin
         if (wr_en) begin
            case (paddr)
               `ADDR_FRAME_WIDTH: fw_q <= pwdat;
               `ADDR_FRAME_HEIGHT: fh_q <= pwdat;
               `ADDR_ORIGIN_X: ox_q <= pwdat;
               `ADDR_ORIGIN_Y: oy_q <= pwdat;
               `ADDR_REGION_W1: aw_q <= pwdat;
               `ADDR_REGION_H1: ah_q <= pwdat;
               `ADDR_ALGORITHM: alg_q <= pwdat[0];
               `ADDR_THRESHOLD: thr_q <= pwdat;
               default: ;
            endcase
         end
         // A new commit written in the hand-over cycle is kept.
         if (wr_en && paddr == `ADDR_COMMIT && pwdat[0])
            commit_q <= 1'b1;
         else if (commit_now)
            commit_q <= 1'b0;
         if (commit_now) begin
            w_q <= fw_q;
            h_q <= fh_q;
            aox_q <= ox_q;
            aoy_q <= oy_q;
            aaw_q <= aw_q;
            aah_q <= ah_q;
         end
         if (step) begin
            x_q <= nx;
            y_q <= ny;
         end
         in_frame_q <= nin;
         ready <= ready_d;
         dvalid_out <= step && in_reg;
         frmsync_out <= step && in_reg && first_px;
         if (step && in_reg) begin
            dout <= edge_bit;
            tags_out <= ct1_q;
         end
      end
   end
endmodule

`default_nettype wire

/* File: verification/edge_detector_properties.sv */
// Purpose: Port-level checks for the edge detector.
// Assumes: Bound to every edge_detector instance.
// Notes: A low clken freezes all state unless srst is high, so pulses may stand longer.
`timescale 1ns/1ps
`default_nettype none
module edge_detector_props #(
   parameter DW = 8,
   parameter TW = 1,
   parameter RW = 24
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic srst,
   input wire logic clken,
   input wire logic ready,
   input wire logic dvalid_in,
   input wire logic frmsync_in,
   input wire logic [DW-1:0] din,
   input wire logic [TW-1:0] tags_in,
   input wire logic dvalid_out,
   input wire logic frmsync_out,
   input wire logic dout,
   input wire logic [TW-1:0] tags_out,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [RW-1:0] pwdat,
   input wire logic [RW-1:0] prdat
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rst; disable iff (1'b0)
      !rstn |-> ready && !dvalid_out && !frmsync_out; endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
   property p_srst;
      srst && clken |=> ready && !dvalid_out && !frmsync_out; endproperty
   a_srst: assert property (p_srst) else $error("bad srst");
   property p_hold; !clken && !srst |=>
      $stable({ready, dvalid_out, dout, tags_out}); endproperty
   a_hold: assert property (p_hold) else $error("moved");
   property p_wr; pwrite && clken && !srst &&
      (paddr < 4'h6 || paddr == 4'h7) ##1 paddr == $past(paddr) |->
      prdat == $past(pwdat); endproperty
   a_wr: assert property (p_wr) else $error("bad readback");
   property p_unmapped; paddr > 4'h8 |-> prdat == '0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_fs; frmsync_out |-> dvalid_out; endproperty
   a_fs: assert property (p_fs) else $error("sync no valid");
   property p_fs1; frmsync_out && clken |=> !frmsync_out; endproperty
   a_fs1: assert property (p_fs1) else $error("long sync");
   property p_ready; $fell(ready) |-> ##[1:1000] ready; endproperty
   a_ready: assert property (p_ready) else $error("stuck");
endmodule
bind edge_detector edge_detector_props #(.DW(DW), .TW(TW), .RW(RW)) chk (
   .clk(clk), .rstn(rstn), .srst(srst), .clken(clken), .ready(ready),
   .dvalid_in(dvalid_in), .frmsync_in(frmsync_in), .din(din),
   .tags_in(tags_in), .dvalid_out(dvalid_out), .frmsync_out(frmsync_out),
   .dout(dout), .tags_out(tags_out), .pwrite(pwrite), .paddr(paddr),
   .pwdat(pwdat), .prdat(prdat));
`default_nettype wire

/* File: verification/video_source.sv */
// Purpose: Upstream pixel source for the edge detector.
// Assumes: The bench fills mem before raising go.
// Notes: Idle data lines toggle so stale pixels never look valid.
`timescale 1ns/1ps
`default_nettype none
module video_source (
   input wire logic clk,
   input wire logic ready,
   input wire logic clken,
   input wire logic go,
   input wire logic slow,
   input wire logic [7:0] npix,
   output logic dvalid_in = 0,
   output logic frmsync_in = 0,
   output logic [7:0] din = 0,
   output logic [0:0] tags_in = 0
);
   logic [7:0] mem [0:63];
   logic held;
   int k = 0;
   always @(posedge clk) begin
      held = dvalid_in && !(ready && clken);
      if (dvalid_in && ready && clken)
         k = k + 1;
      if (!go)
         k = 0;
      if (go && k < npix && (held || !slow || $urandom % 3 == 0)) begin
         dvalid_in <= 1'b1;
         frmsync_in <= k == 0;
         din <= mem[k];
         tags_in <= mem[k][7];
      end else begin
         dvalid_in <= 1'b0;
         frmsync_in <= 1'b0;
         din <= ~din;
      end
   end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the edge detector.
// Assumes: Small 8x6 frames keep the run short.
// Notes: Three instances run the copy, mirror and value edge modes.
`timescale 1ns/1ps
`default_nettype none
`include "edge_detector_regs.vh"
module tb_top;
   logic clk = 0, rstn = 1, srst = 1, clken = 1, go = 0, slow = 0;
   logic pwrite = 0;
   logic [3:0] paddr = 0;
   logic [23:0] pwdat = 0;
   logic [7:0] npix = 48;
   wire ready, dvalid_in, frmsync_in, dvalid_out, frmsync_out, dout;
   wire [7:0] din;
   wire [0:0] tags_in, tags_out;
   wire [23:0] prdat;
   wire dout_mirror, dout_value;
   localparam logic [7:0] fill_val = 8'h5a;
   int bad_count = 0, tests_run = 0, cyc = 0, cnt = 0, cx, cy, s;
   int fw = 8, fh = 6, ox, oy, rw, rh, thr, alg;
   always #5 clk = ~clk;
   edge_detector uut (.clk(clk), .rstn(rstn), .srst(srst), .clken(clken),
      .ready(ready), .dvalid_in(dvalid_in), .frmsync_in(frmsync_in),
      .din(din), .tags_in(tags_in), .dvalid_out(dvalid_out),
      .frmsync_out(frmsync_out), .dout(dout), .tags_out(tags_out),
      .pwrite(pwrite), .paddr(paddr), .pwdat(pwdat), .prdat(prdat));
   edge_detector #(.EDGE_MODE(`EDGE_MIRROR)) uut_mirror (.clk(clk),
      .rstn(rstn), .srst(srst), .clken(clken), .ready(),
      .dvalid_in(dvalid_in), .frmsync_in(frmsync_in), .din(din),
      .tags_in(tags_in), .dvalid_out(), .frmsync_out(),
      .dout(dout_mirror), .tags_out(), .pwrite(pwrite), .paddr(paddr),
      .pwdat(pwdat), .prdat());
   edge_detector #(.EDGE_MODE(`EDGE_VALUE), .EDGE_VAL(fill_val))
      uut_value (.clk(clk), .rstn(rstn), .srst(srst), .clken(clken),
      .ready(), .dvalid_in(dvalid_in), .frmsync_in(frmsync_in),
      .din(din), .tags_in(tags_in), .dvalid_out(), .frmsync_out(),
      .dout(dout_value), .tags_out(), .pwrite(pwrite), .paddr(paddr),
      .pwdat(pwdat), .prdat());
   video_source src (.clk(clk), .ready(ready), .clken(clken), .go(go),
      .slow(slow), .npix(npix), .dvalid_in(dvalid_in),
      .frmsync_in(frmsync_in), .din(din), .tags_in(tags_in));
   // Mode m: 0 copies the edge pixel, 1 mirrors, 2 gives fill_val.
   function automatic int px(int x, int y, int m);
      if (m == 2 && (x < 0 || x >= fw || y < 0 || y >= fh))
         return fill_val;
      if (m == 1) begin
         x = x < 0 ? -x : (x >= fw ? 2 * fw - 2 - x : x);
         y = y < 0 ? -y : (y >= fh ? 2 * fh - 2 - y : y);
      end else begin
         x = x < 0 ? 0 : (x >= fw ? fw - 1 : x);
         y = y < 0 ? 0 : (y >= fh ? fh - 1 : y);
      end
      return src.mem[y * fw + x];
   endfunction
   function automatic logic edge_of(int x, int y, int m);
      int a = 0, b = 0, w;
      for (int i = -1; i <= 1; i++) begin
         w = (alg == 0 && i == 0) ? 2 : 1;
         a += w * (px(x + i, y + 1, m) - px(x + i, y - 1, m));
         b += w * (px(x + 1, y + i, m) - px(x - 1, y + i, m));
      end
      return (a < 0 ? -a : a) + (b < 0 ? -b : b) > thr;
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge clk);
      pwrite <= 1'b1;
      paddr <= a;
      pwdat <= d;
      @(posedge clk);
      pwrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [23:0] e);
      @(posedge clk);
      paddr <= a;
      #1;
      chk(prdat, e);
   endtask
   // Output position walks the region in raster order.
   always @(posedge clk) begin
      cyc++;
      clken <= !slow || $urandom % 4 != 0;
      if (cyc > 20000) begin
         bad_count++;
         test_done();
      end
      if (rstn && dvalid_out && clken) begin
         cx = ox + cnt % rw;
         cy = oy + cnt / rw;
         chk(dout, edge_of(cx, cy, 0));
         chk(dout_mirror, edge_of(cx, cy, 1));
         chk(dout_value, edge_of(cx, cy, 2));
         chk(frmsync_out, cnt == 0);
         chk(tags_out, src.mem[cy * fw + cx][7]);
         cnt++;
      end
   end
   initial begin
      rstn <= 1'b0;
      s = $urandom(32'hfda0946b);
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      rd(`ADDR_FRAME_WIDTH, `RST_FRAME_WIDTH);
      rd(`ADDR_REGION_H1, `RST_REGION_H1);
      rd(`ADDR_ALGORITHM, 0);
      wr(4'hc, 24'h5a5a5a);
      rd(4'hc, 0);
      wr(`ADDR_FRAME_WIDTH, fw);
      wr(`ADDR_FRAME_HEIGHT, fh);
      for (s = 0; s < 4; s++) begin
         alg = s % 2;
         thr = $urandom % 400;
         ox = s / 3 * 2;
         oy = s / 3;
         rw = s == 3 ? 3 : fw;
         rh = s == 3 ? 2 : fh;
         wr(`ADDR_ORIGIN_X, ox);
         wr(`ADDR_ORIGIN_Y, oy);
         wr(`ADDR_REGION_W1, rw - 1);
         wr(`ADDR_REGION_H1, rh - 1);
         wr(`ADDR_ALGORITHM, alg);
         wr(`ADDR_THRESHOLD, thr);
         rd(`ADDR_THRESHOLD, thr);
         wr(`ADDR_COMMIT, 1);
         for (int i = 0; i < 48; i++)
            src.mem[i] = $urandom;
         slow <= s == 2;
         cnt = 0;
         go <= 1'b1;
         repeat (3000) if (cnt < rw * rh) @(posedge clk);
         repeat (20) @(posedge clk);
         chk(cnt, rw * rh);
         go <= 1'b0;
         slow <= 1'b0;
         rd(`ADDR_COMMIT, 0);
      end
      test_done();
   end
endmodule
`default_nettype wire
